// *** rtl/pmc_regs.sv ***
// Purpose: Pin function / floppy mode and port extended setup configuration registers
// Assumes: Index register and configuration state come from the configuration logic
// Notes: Access is gated by configuration state and index match
//
// Notes on behaviour
// - Pin mode register reached only at index 03
// - Pin mode register resets to 70
// - Bit 1 picks normal or enhanced floppy
// - Bit 3 of pin mode reads zero
// - Bit 4 forces drive-density output high
// - Bits 6,5 pick floppy interface mode
// - Bits 7,2 pick shared pin function
// - Shared pin undriven until configured
// - Port setup register reached only at index 04
// - Port setup register resets to 00
// - Bits 1:0 pick extended parallel mode
// - Bits 3:2 pick floppy-over-parallel mode
// - Bit 4 sets serial one divisor
// - Bit 5 sets serial two divisor
// - Bit 6 picks EPP revision
// - Bit 7 of port setup reads zero
// - Printer bit high overrides extended modes
// - Combined mode enters EPP via mode 100
// - MIDI divisor yields 31.25 kbaud
`timescale 1ns/100ps
module pmc_regs
  import pmc_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input pmc_cfg_req_t cfg_req_in,
  input wire logic printer_mode_in,
  input wire logic [2:0] ecr_mode_in,
  input wire logic uart_ref_en_in,
  input wire logic addr_qual_n_in,
  input wire logic clock_run_n_in,
  input wire logic dens_prog_in,
  input wire logic fdc_out_tristate_in,
  output logic [7:0] rdata_out,
  output logic rdata_valid_out,
  output pmc_settings_t settings_out,
  output logic epp_active_out,
  output logic uart1_pre_tick_out,
  output logic uart1_baud16_tick_out,
  output logic uart2_pre_tick_out,
  output logic uart2_baud16_tick_out,
  output logic addr_qualify_out_n,
  output logic addr_qualify_oe_out,
  output logic drive_density_out_b,
  output logic drive_density_oe_out
);
  logic [7:0] pin_mode_reg; // Pin function and floppy mode
  logic [7:0] port_ext_reg; // Port extended setup
  logic pin_configured_reg; // Shared pin function written since reset
  logic hit_pin_mode; // Index selects pin mode register
  logic hit_port_ext; // Index selects port setup register
  pmc_pin_fn_t pin_fn; // Effective shared pin function
  pmc_settings_t settings_next; // Decoded settings
  logic pin_dens; // Raw drive density from mux

  // Index decode, shared by read and write paths
  function automatic logic idx_hit(input pmc_cfg_req_t req, input logic [7:0] idx);
    idx_hit = req.cfg_state && (req.index == idx);
  endfunction : idx_hit

  assign hit_pin_mode = idx_hit(cfg_req_in, PMC_IDX_PIN_MODE);
  assign hit_port_ext = idx_hit(cfg_req_in, PMC_IDX_PORT_EXT);

  // Pin mode register storage
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_mode_reg <= PMC_RST_PIN_MODE;
    end else if (cfg_req_in.wr && hit_pin_mode) begin
      pin_mode_reg <= cfg_req_in.wdata & PMC_RMASK_PIN_MODE;
    end
  end

  // Port setup register storage; other writes leave it alone
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      port_ext_reg <= PMC_RST_PORT_EXT;
    end else if (cfg_req_in.wr && hit_port_ext) begin
      port_ext_reg <= cfg_req_in.wdata & PMC_RMASK_PORT_EXT;
    end
  end

  // Shared pin becomes configured on first write to pin mode register
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_configured_reg <= 1'b0;
    end else if (cfg_req_in.wr && hit_pin_mode) begin
      pin_configured_reg <= 1'b1;
    end
  end

  // Read path, zero and not valid on a miss
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
      rdata_valid_out <= 1'b0;
    end else begin
      rdata_valid_out <= 1'b0;
      rdata_out <= 8'h00;
      if (cfg_req_in.rd && hit_pin_mode) begin
        rdata_out <= pin_mode_reg & PMC_RMASK_PIN_MODE;
        rdata_valid_out <= 1'b1;
      end else if (cfg_req_in.rd && hit_port_ext) begin
        rdata_out <= port_ext_reg & PMC_RMASK_PORT_EXT;
        rdata_valid_out <= 1'b1;
      end
    end
  end

  // Shared pin function decode
  always_comb begin
    pin_fn = PMC_PIN_TRISTATE;
    if (pin_configured_reg && pin_mode_reg[PMC_B_PIN_SEL_HI]) begin
      pin_fn = pin_mode_reg[PMC_B_PIN_SEL_LO] ? PMC_PIN_CLOCK_RUN : PMC_PIN_ADDR_QUAL;
    end
  end

  // Settings decode from both registers
  always_comb begin
    settings_next = '0;
    settings_next.floppy_enh2 = pin_mode_reg[PMC_B_FLOPPY_ENH2];
    settings_next.pwrgood_game = pin_mode_reg[PMC_B_PWRGOOD_GAME];
    unique case ({pin_mode_reg[PMC_B_IDENT], pin_mode_reg[PMC_B_ENCODE]})
      2'h3: settings_next.fdc_if = PMC_FDC_AT;
      2'h2: settings_next.fdc_if = PMC_FDC_RSVD;
      2'h1: settings_next.fdc_if = PMC_FDC_SYS2;
      2'h0: settings_next.fdc_if = PMC_FDC_SYS3;
    endcase
    settings_next.pin_fn = pin_fn;
    if (printer_mode_in) begin
      settings_next.par_mode = PMC_PAR_PRINTER;
    end else begin
      unique case (port_ext_reg[PMC_B_PAR_MODE_LO +: 2])
        2'h0: settings_next.par_mode = PMC_PAR_SPP;
        2'h1: settings_next.par_mode = PMC_PAR_EPP_SPP;
        2'h2: settings_next.par_mode = PMC_PAR_ECP;
        2'h3: settings_next.par_mode = PMC_PAR_ECP_EPP;
      endcase
    end
    settings_next.ppf_mode = pmc_ppf_mode_t'(port_ext_reg[PMC_B_PP_FLOPPY_LO +: 2]);
    settings_next.epp_rev17 = port_ext_reg[PMC_B_EPP_TYPE];
    settings_next.uart1_div = port_ext_reg[PMC_B_MIDI_1] ? PMC_DIV_MIDI : PMC_DIV_NORMAL;
    settings_next.uart2_div = port_ext_reg[PMC_B_MIDI_2] ? PMC_DIV_MIDI : PMC_DIV_NORMAL;
  end

  // Registered settings outputs
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      settings_out <= '0;
      settings_out.fdc_if <= PMC_FDC_AT;
      settings_out.par_mode <= PMC_PAR_PRINTER;
      settings_out.uart1_div <= PMC_DIV_NORMAL;
      settings_out.uart2_div <= PMC_DIV_NORMAL;
    end else begin
      settings_out <= settings_next;
    end
  end

  // EPP active: direct EPP mode, or combined mode with ECP mode field at 100
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      epp_active_out <= 1'b0;
    end else begin
      epp_active_out <= (settings_next.par_mode == PMC_PAR_EPP_SPP) ||
                        ((settings_next.par_mode == PMC_PAR_ECP_EPP) && (ecr_mode_in == PMC_ECR_MODE_EPP));
    end
  end

  // Drive-density pin tristates with the floppy outputs
  assign drive_density_oe_out = !fdc_out_tristate_in;

  // Serial port one prescaler
  pmc_midi_div u_div1 (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .ref_en_in(uart_ref_en_in),
    .midi_sel_in(port_ext_reg[PMC_B_MIDI_1]),
    .pre_tick_out(uart1_pre_tick_out),
    .baud16_tick_out(uart1_baud16_tick_out)
  );

  // Serial port two prescaler
  pmc_midi_div u_div2 (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .ref_en_in(uart_ref_en_in),
    .midi_sel_in(port_ext_reg[PMC_B_MIDI_2]),
    .pre_tick_out(uart2_pre_tick_out),
    .baud16_tick_out(uart2_baud16_tick_out)
  );

  // Shared pin and drive-density drivers
  pmc_pin_mux u_mux (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .pin_fn_in(pin_fn),
    .addr_qual_n_in(addr_qual_n_in),
    .clock_run_n_in(clock_run_n_in),
    .dens_force_in(pin_mode_reg[PMC_B_DENS_FORCE]),
    .dens_prog_in(dens_prog_in),
    .shared_pin_out(addr_qualify_out_n),
    .shared_pin_oe_out(addr_qualify_oe_out),
    .drive_density_out_b(pin_dens)
  );

  assign drive_density_out_b = pin_dens;
endmodule : pmc_regs

// *** rtl/pmc_pkg.sv ***
// Purpose: Shared constants and types for the pin and port mode configuration registers
// Assumes: 8-bit configuration data, index-addressed access in configuration state
// Notes: Offsets, reset values and field positions live here only
package pmc_pkg;
  // Index values that reach each register
  localparam logic [7:0] PMC_IDX_PIN_MODE = 8'h03;
  localparam logic [7:0] PMC_IDX_PORT_EXT = 8'h04;
  // Power-up defaults
  localparam logic [7:0] PMC_RST_PIN_MODE = 8'h70;
  localparam logic [7:0] PMC_RST_PORT_EXT = 8'h00;
  // Read masks: reserved bits read as zero
  localparam logic [7:0] PMC_RMASK_PIN_MODE = 8'hf7;
  localparam logic [7:0] PMC_RMASK_PORT_EXT = 8'h7f;
  // Field positions, pin function and floppy mode register
  localparam int PMC_B_PWRGOOD_GAME = 0;
  localparam int PMC_B_FLOPPY_ENH2 = 1;
  localparam int PMC_B_PIN_SEL_LO = 2;
  localparam int PMC_B_DENS_FORCE = 4;
  localparam int PMC_B_ENCODE = 5;
  localparam int PMC_B_IDENT = 6;
  localparam int PMC_B_PIN_SEL_HI = 7;
  // Field positions, port extended setup register
  localparam int PMC_B_PAR_MODE_LO = 0;
  localparam int PMC_B_PP_FLOPPY_LO = 2;
  localparam int PMC_B_MIDI_1 = 4;
  localparam int PMC_B_MIDI_2 = 5;
  localparam int PMC_B_EPP_TYPE = 6;
  // Serial clock divisors
  localparam logic [3:0] PMC_DIV_NORMAL = 4'hd;
  localparam logic [3:0] PMC_DIV_MIDI = 4'hc;
  // Oversampling divisor after the MIDI prescale (2 MHz / 16 = 125 kHz)
  localparam logic [4:0] PMC_DIV_OVERSAMPLE = 5'h10;
  // Mode code written into the ECP control mode field to enter EPP
  localparam logic [2:0] PMC_ECR_MODE_EPP = 3'h4;
  // Parallel port modes
  typedef enum logic [2:0] {
    PMC_PAR_PRINTER, PMC_PAR_SPP, PMC_PAR_EPP_SPP, PMC_PAR_ECP, PMC_PAR_ECP_EPP
  } pmc_par_mode_t;
  // Floppy interface modes
  typedef enum logic [1:0] {
    PMC_FDC_AT, PMC_FDC_RSVD, PMC_FDC_SYS2, PMC_FDC_SYS3
  } pmc_fdc_if_t;
  // Shared pin functions
  typedef enum logic [1:0] {
    PMC_PIN_TRISTATE, PMC_PIN_ADDR_QUAL, PMC_PIN_CLOCK_RUN
  } pmc_pin_fn_t;
  // Floppy over parallel port modes
  typedef enum logic [1:0] {
    PMC_PPF_NORMAL, PMC_PPF_A, PMC_PPF_B, PMC_PPF_RSVD
  } pmc_ppf_mode_t;
  // Configuration access request
  typedef struct packed {
    logic cfg_state;
    logic [7:0] index;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } pmc_cfg_req_t;
  // Decoded settings bundle
  typedef struct packed {
    logic floppy_enh2;
    pmc_fdc_if_t fdc_if;
    pmc_pin_fn_t pin_fn;
    logic pwrgood_game;
    pmc_par_mode_t par_mode;
    pmc_ppf_mode_t ppf_mode;
    logic epp_rev17;
    logic [3:0] uart1_div;
    logic [3:0] uart2_div;
  } pmc_settings_t;
endpackage : pmc_pkg

// *** rtl/pmc_midi_div.sv ***
// Purpose: Serial clock prescaler, divide by 13 or by 12 for MIDI
// Assumes: Input clock enable at the serial reference rate
// Notes: Emits one-cycle enable pulses; oversample tick comes in the same cycle as every 16th prescale tick
`timescale 1ns/100ps
module pmc_midi_div
  import pmc_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic ref_en_in,
  input wire logic midi_sel_in,
  output logic pre_tick_out,
  output logic baud16_tick_out
);
  logic [3:0] pre_cnt_reg; // Prescale counter
  logic [4:0] os_cnt_reg; // Oversample counter
  logic [3:0] div_sel; // Selected divisor
  logic pre_wrap; // Prescale end

  // Divisor choice
  assign div_sel = midi_sel_in ? PMC_DIV_MIDI : PMC_DIV_NORMAL;
  assign pre_wrap = ref_en_in && (pre_cnt_reg == div_sel - 4'h1);

  // Prescale counter, restarts when divisor shrinks to or below count
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pre_cnt_reg <= 4'h0;
    end else if (ref_en_in) begin
      if (pre_wrap || pre_cnt_reg >= div_sel) begin
        pre_cnt_reg <= 4'h0;
      end else begin
        pre_cnt_reg <= pre_cnt_reg + 4'h1;
      end
    end
  end

  // Oversample counter, 2 MHz / 16 gives 125 kHz for 31.25 kbaud
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      os_cnt_reg <= 5'h00;
    end else if (pre_wrap) begin
      os_cnt_reg <= (os_cnt_reg == PMC_DIV_OVERSAMPLE - 5'h01) ? 5'h00 : os_cnt_reg + 5'h01;
    end
  end

  // Registered tick outputs
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pre_tick_out <= 1'b0;
      baud16_tick_out <= 1'b0;
    end else begin
      pre_tick_out <= pre_wrap;
      baud16_tick_out <= pre_wrap && (os_cnt_reg == PMC_DIV_OVERSAMPLE - 5'h01);
    end
  end
endmodule : pmc_midi_div

// *** rtl/pmc_pin_mux.sv ***
// Purpose: Shared address-qualify / clock-run pin and drive-density output
// Assumes: Pin function already decoded
// Notes: Pin stays undriven until a function is configured
`timescale 1ns/100ps
module pmc_pin_mux
  import pmc_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input pmc_pin_fn_t pin_fn_in,
  input wire logic addr_qual_n_in,
  input wire logic clock_run_n_in,
  input wire logic dens_force_in,
  input wire logic dens_prog_in,
  output logic shared_pin_out,
  output logic shared_pin_oe_out,
  output logic drive_density_out_b
);
  // Shared pin drive, high impedance until configured
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      shared_pin_out <= 1'b1;
      shared_pin_oe_out <= 1'b0;
    end else begin
      unique case (pin_fn_in)
        PMC_PIN_ADDR_QUAL: begin
          shared_pin_out <= addr_qual_n_in;
          shared_pin_oe_out <= 1'b1;
        end
        PMC_PIN_CLOCK_RUN: begin
          shared_pin_out <= clock_run_n_in;
          shared_pin_oe_out <= 1'b1;
        end
        default: begin
          shared_pin_out <= 1'b1;
          shared_pin_oe_out <= 1'b0;
        end
      endcase
    end
  end

  // Drive-density output, forced high on request
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      drive_density_out_b <= 1'b1;
    end else begin
      drive_density_out_b <= dens_force_in ? 1'b1 : dens_prog_in;
    end
  end
endmodule : pmc_pin_mux

// *** test/pmc_regs_assertions.sv ***
// Purpose: Port-level checker for the pin and port mode configuration registers
// Assumes: Single clock domain, reset asynchronous and active high
// Notes: Settings are seen two edges after the write that sets them
`timescale 1ns/100ps
module pmc_regs_assertions
  import pmc_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input pmc_cfg_req_t cfg_req_in,
  input wire logic printer_mode_in,
  input wire logic fdc_out_tristate_in,
  input wire logic [7:0] rdata_out,
  input wire logic rdata_valid_out,
  input pmc_settings_t settings_out,
  input wire logic uart1_pre_tick_out,
  input wire logic uart1_baud16_tick_out,
  input wire logic addr_qualify_oe_out,
  input wire logic drive_density_oe_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // Index matches inside configuration state
  logic hit_pin;
  logic hit_ext;
  assign hit_pin = cfg_req_in.cfg_state && cfg_req_in.index == PMC_IDX_PIN_MODE;
  assign hit_ext = cfg_req_in.cfg_state && cfg_req_in.index == PMC_IDX_PORT_EXT;
  AST_RD_OK: assert property (cfg_req_in.rd && (hit_pin || hit_ext) |=> rdata_valid_out)
    else $error("accepted read not answered");
  AST_RD_REFUSE: assert property (!(cfg_req_in.rd && (hit_pin || hit_ext)) |=> !rdata_valid_out)
    else $error("refused read answered");
  AST_RD_ZERO: assert property (!rdata_valid_out |-> rdata_out == 8'h00)
    else $error("read data shown while not valid");
  AST_PIN_RSVD: assert property (rdata_valid_out && $past(hit_pin) |-> !rdata_out[3])
    else $error("pin mode bit 3 read as one");
  AST_EXT_RSVD: assert property (rdata_valid_out && $past(hit_ext) |-> !rdata_out[7])
    else $error("port setup bit 7 read as one");
  AST_PIN_DECODE: assert property (cfg_req_in.wr && hit_pin |=> ##1
    settings_out.floppy_enh2 == $past(cfg_req_in.wdata[1], 2)
    && settings_out.fdc_if == pmc_fdc_if_t'(~$past(cfg_req_in.wdata[6:5], 2)))
    else $error("floppy mode decode wrong");
  AST_EXT_DECODE: assert property (cfg_req_in.wr && hit_ext |=> ##1
    settings_out.ppf_mode == pmc_ppf_mode_t'($past(cfg_req_in.wdata[3:2], 2))
    && settings_out.epp_rev17 == $past(cfg_req_in.wdata[6], 2)
    && settings_out.uart1_div == ($past(cfg_req_in.wdata[4], 2) ? PMC_DIV_MIDI : PMC_DIV_NORMAL)
    && settings_out.uart2_div == ($past(cfg_req_in.wdata[5], 2) ? PMC_DIV_MIDI : PMC_DIV_NORMAL))
    else $error("port setup decode wrong");
  AST_PRINTER: assert property (1'b1 |=> (settings_out.par_mode == PMC_PAR_PRINTER) == $past(printer_mode_in))
    else $error("printer mode not followed");
  AST_PIN_HIZ: assert property (addr_qualify_oe_out |-> settings_out.pin_fn != PMC_PIN_TRISTATE
    || $past(settings_out.pin_fn) != PMC_PIN_TRISTATE)
    else $error("shared pin driven while unconfigured");
  AST_DENS_OE: assert property (drive_density_oe_out == !fdc_out_tristate_in)
    else $error("density enable ignores tristate control");
  AST_BAUD16: assert property (uart1_baud16_tick_out |-> uart1_pre_tick_out)
    else $error("oversample tick off prescale tick");
endmodule : pmc_regs_assertions

// *** test/pmc_regs_bench.sv ***
// Purpose: Self-checking bench for the pin and port mode configuration registers
// Assumes: Inputs change on the falling edge; reads answer one cycle later
// Notes: Reference copies of both registers are kept here
`timescale 1ns/100ps
module pmc_regs_bench
  import pmc_pkg::*;
;
  logic core_clk_in, rst_in, printer_mode_in, uart_ref_en_in, addr_qual_n_in, clock_run_n_in;
  logic dens_prog_in, fdc_out_tristate_in, rdata_valid_out, epp_active_out, uart1_pre_tick_out;
  logic uart1_baud16_tick_out, uart2_pre_tick_out, uart2_baud16_tick_out, addr_qualify_out_n;
  logic addr_qualify_oe_out, drive_density_out_b, drive_density_oe_out;
  logic [2:0] ecr_mode_in;
  logic [7:0] rdata_out, pin_m, ext_m, d;
  logic pin_wr; // Pin mode written since reset
  pmc_cfg_req_t cfg_req_in;
  pmc_settings_t settings_out;
  logic [7:0] exp_q[$]; // Expected read data
  int n_fail, total_checks, n1p, n1b, n2p, n2b;
  pmc_regs i_pmc_regs (.core_clk_in, .rst_in, .cfg_req_in, .printer_mode_in, .ecr_mode_in, .uart_ref_en_in,
    .addr_qual_n_in, .clock_run_n_in, .dens_prog_in, .fdc_out_tristate_in, .rdata_out, .rdata_valid_out,
    .settings_out, .epp_active_out, .uart1_pre_tick_out, .uart1_baud16_tick_out, .uart2_pre_tick_out,
    .uart2_baud16_tick_out, .addr_qualify_out_n, .addr_qualify_oe_out, .drive_density_out_b,
    .drive_density_oe_out);
  // Clock, 20 ns period
  always #10 core_clk_in = ~core_clk_in;
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Verdict and end of run
  task automatic results();
    $display("checks %0d errors %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results
  // One access cycle; notes the expected read, then updates the copies
  task automatic acc(input logic cs, input logic [7:0] idx, input logic w, input logic r, input logic [7:0] dat);
    logic hit;
    @(negedge core_clk_in);
    cfg_req_in = '{cs, idx, w, r, dat};
    hit = cs && (idx == PMC_IDX_PIN_MODE || idx == PMC_IDX_PORT_EXT);
    if (hit && r) begin
      exp_q.push_back(idx == PMC_IDX_PIN_MODE ? pin_m : ext_m);
    end
    if (hit && w && idx == PMC_IDX_PIN_MODE) begin
      pin_m = dat & 8'hf7;
      pin_wr = 1'b1;
    end
    if (hit && w && idx == PMC_IDX_PORT_EXT) begin
      ext_m = dat & 8'h7f;
    end
  endtask : acc
  // Let settings land, then compare every decoded output
  task automatic chk_all();
    pmc_settings_t e;
    repeat (5) @(negedge core_clk_in);
    e.floppy_enh2 = pin_m[1];
    e.fdc_if = pmc_fdc_if_t'(~pin_m[6:5]);
    e.pin_fn = (!pin_wr || !pin_m[7]) ? PMC_PIN_TRISTATE : (pin_m[2] ? PMC_PIN_CLOCK_RUN : PMC_PIN_ADDR_QUAL);
    e.pwrgood_game = pin_m[0];
    e.par_mode = printer_mode_in ? PMC_PAR_PRINTER : pmc_par_mode_t'(3'(ext_m[1:0]) + 3'h1);
    e.ppf_mode = pmc_ppf_mode_t'(ext_m[3:2]);
    e.epp_rev17 = ext_m[6];
    e.uart1_div = ext_m[4] ? PMC_DIV_MIDI : PMC_DIV_NORMAL;
    e.uart2_div = ext_m[5] ? PMC_DIV_MIDI : PMC_DIV_NORMAL;
    check(32'(settings_out), 32'(e));
    check(32'(epp_active_out), 32'(!printer_mode_in && (ext_m[1:0] == 2'h1
      || (ext_m[1:0] == 2'h3 && ecr_mode_in == PMC_ECR_MODE_EPP))));
    check(32'(addr_qualify_oe_out), 32'(e.pin_fn != PMC_PIN_TRISTATE));
    if (addr_qualify_oe_out === 1'b1) begin
      check(32'(addr_qualify_out_n), 32'(pin_m[2] ? clock_run_n_in : addr_qual_n_in));
    end
    if (!fdc_out_tristate_in) begin
      check(32'(drive_density_out_b), 32'(pin_m[4] | dens_prog_in));
    end
    check(32'(drive_density_oe_out), 32'(!fdc_out_tristate_in));
  endtask : chk_all
  // Read results taken off the queue in order
  always @(negedge core_clk_in) begin
    if (rdata_valid_out === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(32'(rdata_out), 32'h1ff);
      end else begin
        check(32'(rdata_out), 32'(exp_q.pop_front()));
      end
    end
  end
  // Watchdog
  initial begin
    repeat (6000) @(posedge core_clk_in);
    n_fail++;
    results();
  end
  // Main sequence
  initial begin
    core_clk_in = 1'b0;
    rst_in = 1'b1;
    cfg_req_in = '0;
    printer_mode_in = 1'b1;
    ecr_mode_in = 3'h0;
    uart_ref_en_in = 1'b0;
    addr_qual_n_in = 1'b0;
    clock_run_n_in = 1'b1;
    dens_prog_in = 1'b0;
    fdc_out_tristate_in = 1'b0;
    pin_m = 8'h70;
    ext_m = 8'h00;
    pin_wr = 1'b0;
    void'($urandom(32'h9b18));
    repeat (16) @(posedge core_clk_in);
    @(negedge core_clk_in) rst_in = 1'b0;
    chk_all();
    acc(1, PMC_IDX_PIN_MODE, 0, 1, 8'h00);
    acc(1, PMC_IDX_PORT_EXT, 0, 1, 8'h00);
    acc(0, PMC_IDX_PIN_MODE, 1, 1, 8'hff);
    acc(1, 8'h05, 1, 1, 8'hff);
    acc(0, PMC_IDX_PORT_EXT, 1, 1, 8'hff);
    acc(1, PMC_IDX_PIN_MODE, 0, 1, 8'h00);
    acc(1, PMC_IDX_PORT_EXT, 0, 1, 8'h00);
    acc(0, 8'h00, 0, 0, 8'h00);
    chk_all();
    // Every field code, with a same-cycle write and read
    for (int k = 0; k < 16; k++) begin
      d = 8'($urandom);
      printer_mode_in = k >= 12;
      ecr_mode_in = k[2] ? PMC_ECR_MODE_EPP : 3'($urandom);
      dens_prog_in = d[0];
      fdc_out_tristate_in = k == 5;
      acc(1, PMC_IDX_PIN_MODE, 1, 1, {k[2], k[1:0], d[4:3], k[3], d[1:0]});
      acc(1, PMC_IDX_PORT_EXT, 1, 0, {d[7:4], 4'(k)});
      acc(1, PMC_IDX_PIN_MODE, 0, 1, 8'h00);
      acc(1, PMC_IDX_PORT_EXT, 0, 1, 8'h00);
      acc(0, 8'h00, 0, 0, 8'h00);
      chk_all();
    end
    // Divisors: port one at 12, port two at 13
    acc(1, PMC_IDX_PORT_EXT, 1, 0, 8'h10);
    acc(0, 8'h00, 0, 0, 8'h00);
    chk_all();
    uart_ref_en_in = 1'b1;
    repeat (1248) begin
      @(negedge core_clk_in);
      n1p += int'(uart1_pre_tick_out);
      n1b += int'(uart1_baud16_tick_out);
      n2p += int'(uart2_pre_tick_out);
      n2b += int'(uart2_baud16_tick_out);
    end
    uart_ref_en_in = 1'b0;
    check(32'(n1p), 32'(1248 / 12));
    check(32'(n2p), 32'(1248 / 13));
    check(32'(n1b), 32'(1248 / 12 / 16));
    check(32'(n2b), 32'(1248 / 13 / 16));
    // Reset in mid-run restores defaults and tristates the pin
    @(negedge core_clk_in) rst_in = 1'b1;
    repeat (3) @(negedge core_clk_in);
    rst_in = 1'b0;
    pin_m = 8'h70;
    ext_m = 8'h00;
    pin_wr = 1'b0;
    chk_all();
    acc(1, PMC_IDX_PIN_MODE, 0, 1, 8'h00);
    acc(1, PMC_IDX_PORT_EXT, 0, 1, 8'h00);
    acc(0, 8'h00, 0, 0, 8'h00);
    repeat (4) @(negedge core_clk_in);
    check(32'(exp_q.size()), 32'h0);
    results();
  end
endmodule : pmc_regs_bench
bind pmc_regs pmc_regs_assertions i_pmc_regs_assertions (.core_clk_in, .rst_in, .cfg_req_in, .printer_mode_in,
  .fdc_out_tristate_in, .rdata_out, .rdata_valid_out, .settings_out, .uart1_pre_tick_out, .uart1_baud16_tick_out,
  .addr_qualify_oe_out, .drive_density_oe_out);
